// *** tb/frontend_regs_asserts.sv ***
`timescale 1ns/1ps
module frontend_regs_asserts (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Serial link.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic serial_data_out_pin,
  input wire logic serial_data_out_oe,
  input wire logic miso_line
);
  logic [8:0] low_cnt;
  logic [5:0] rise_cnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Counters are cleared while deselected, so a frame is measured alone.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      low_cnt <= 9'h000;
      rise_cnt <= 6'h00;
    end else if (cs_n) begin
      low_cnt <= 9'h000;
      rise_cnt <= 6'h00;
    end else begin
      low_cnt <= low_cnt + 9'h001;
      rise_cnt <= rise_cnt + ($rose(sclk) ? 6'h01 : 6'h00);
    end
  end
  AST_OE_OFF_AT_SELECT: assert property ($fell(cs_n) |-> !serial_data_out_oe)
    else $error("data out driven at frame start");
  AST_OE_OFF_AFTER: assert property ($rose(cs_n) |-> ##[1:5] !serial_data_out_oe)
    else $error("data out still driven after frame");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("serial clock high phase wrong");
  AST_MOSI_STABLE: assert property (sclk && $past(sclk) |-> $stable(mosi))
    else $error("data in changed while clock high");
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("serial clock active while deselected");
  AST_FRAME_LEN: assert property ($rose(cs_n) |-> low_cnt inside {[9'h100:9'h108]})
    else $error("frame length wrong");
  AST_FRAME_BITS: assert property ($rose(cs_n) |-> rise_cnt == 6'h20)
    else $error("frame bit count wrong");
  AST_DESELECT_GAP: assert property ($rose(cs_n) |-> cs_n[*3])
    else $error("deselect gap too short");
  cover property ($rose(cs_n) && rise_cnt == 6'h20);
  cover property (serial_data_out_oe && miso_line);
  cover property ($fell(cs_n));
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  import frontend_regs_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [REG_W-1:0] wdata = 24'h000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic done = 1'b0;
  logic pos_c = 1'b0;
  logic neg_c = 1'b0;
  logic prp = 1'b0;
  logic [FLAG_W-1:0] flags = 13'h0000;
  logic [REG_W-1:0] rdata, q;
  logic pos_o, neg_o, third_o, dclk, dclk_oe, pdn, third_sel;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  int h, t3, t6;
  logic [2:0] codes [6] = '{DIV_BY_2, DIV_BY_4, DIV_BY_6, DIV_BY_8, DIV_BY_12, DIV_BY_1};
  int halves [6] = '{1, 2, 3, 4, 6, 1};
  serial_link_if link();
  frontend_host frontend_host_i (.clk_sys(clk_sys), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .link(link));
  frontend_regs frontend_regs_i (.clk_sys(clk_sys), .resetn(resetn), .link(link),
    .diagnostics_done_pin(done), .diagnostic_fault_flags_flags_in(flags), .pos_bridge_ctrl(pos_c),
    .neg_bridge_ctrl(neg_c), .prp_start(prp), .pos_bridge_output(pos_o),
    .neg_bridge_output(neg_o), .third_emitter_output(third_o), .divided_clock_output(dclk),
    .divided_clock_oe(dclk_oe), .dynamic_power_down_start(pdn),
    .third_emitter_select(third_sel));
  frontend_regs_asserts asserts_i (.clk_sys(clk_sys), .resetn(resetn), .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .serial_data_out_pin(link.serial_data_out_pin),
    .serial_data_out_oe(link.serial_data_out_oe), .miso_line(link.miso_line));

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic finish_test();
    if (err_total == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [REG_W-1:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One device access takes about 300 cycles and the run under 20000.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      chk("timeout", 24'h000001, 24'h000000);
      finish_test();
    end
  end

  task automatic port_wr(input logic [2:0] a, input logic [REG_W-1:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  task automatic port_rd(input logic [2:0] a, output logic [REG_W-1:0] d);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // One device access: command, data, start, wait for idle, fetch the answer.
  task automatic dev(input logic rf, input logic [6:0] a, input logic [REG_W-1:0] d,
      output logic [REG_W-1:0] r);
    port_wr(HOST_ADDR_REG, {16'h0000, rf, a});
    port_wr(HOST_DATA_REG, d);
    port_wr(HOST_GO_REG, 24'h000001);
    r = 24'h000001;
    for (int n = 0; n < 400 && r[0] === 1'b1; n++) port_rd(HOST_STATUS_REG, r);
    port_rd(HOST_RX_REG, r);
  endtask

  // Inputs are inverted after capture so a late change would show up.
  task automatic capture(input logic [FLAG_W-1:0] f);
    @(posedge clk_sys);
    done <= 1'b0;
    flags <= f;
    @(posedge clk_sys);
    done <= 1'b1;
    @(posedge clk_sys);
    flags <= ~f;
  endtask

  task automatic sync_rise();
    for (int i = 0; i < 40 && dclk !== 1'b0; i++) @(negedge clk_sys);
    for (int i = 0; i < 40 && dclk !== 1'b1; i++) @(negedge clk_sys);
  endtask

  task automatic pdn_time(output int t);
    sync_rise();
    @(posedge clk_sys);
    prp <= 1'b1;
    @(posedge clk_sys);
    prp <= 1'b0;
    for (t = 0; t < 200 && pdn !== 1'b1; t++) @(negedge clk_sys);
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      dev(1'b1, DIAGNOSTIC_FAULT_FLAGS_FLAGS_ADDR + 7'(a), 24'h000000, q);
      chk("reset_reg", q, REG_RESET);
    end
    chk("clk_oe_rst", REG_W'(dclk_oe), 24'h000001);
    for (int b = 0; b <= FLAG_W; b++) begin
      capture(b == FLAG_W ? 13'h1FFF : 13'h0001 << b);
      dev(1'b1, DIAGNOSTIC_FAULT_FLAGS_FLAGS_ADDR, 24'h000000, q);
      chk("diagnostic_fault_flags_flags", q, b == FLAG_W ? 24'h001FFF : 24'h000001 << b);
    end
    dev(1'b0, DIAGNOSTIC_FAULT_FLAGS_FLAGS_ADDR, 24'hFFFFFF, q);
    dev(1'b1, DIAGNOSTIC_FAULT_FLAGS_FLAGS_ADDR, 24'h000000, q);
    chk("diagnostic_fault_flags_ro", q, 24'h001FFF);
    for (int s = 1; s >= 0; s--) begin
      // Only the select bit is written; no current setting exists here.
      dev(1'b0, CTRL_ADDR, s == 1 ? 24'h008000 : 24'h000000, q);
      @(posedge clk_sys);
      pos_c <= 1'b1;
      neg_c <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1;
      chk("pos_out", REG_W'(pos_o), REG_W'(1 - s));
      chk("third_out", REG_W'(third_o), REG_W'(s));
      chk("neg_out", REG_W'(neg_o), 24'h000001);
      chk("third_sel", REG_W'(third_sel), REG_W'(s));
    end
    dev(1'b0, CTRL_ADDR, 24'h000018, q);
    dev(1'b1, CTRL_ADDR, 24'h000000, q);
    chk("data_out_tri", q, 24'h000000);
    chk("clk_oe_tri", REG_W'(dclk_oe), 24'h000000);
    dev(1'b0, CTRL_ADDR, 24'h000008, q);
    dev(1'b1, CTRL_ADDR, 24'h000000, q);
    chk("ctrl_rw", q, 24'h000008);
    for (int i = 0; i < 6; i++) begin
      dev(1'b0, CTRL_ADDR, {21'h000000, codes[i]}, q);
      sync_rise();
      for (h = 0; h < 40 && dclk === 1'b1; h++) @(negedge clk_sys);
      chk("clk_half", REG_W'(h), REG_W'(halves[i]));
    end
    dev(1'b0, CTRL_ADDR, {21'h000000, DIV_BY_4}, q);
    pdn_time(t3);
    chk("pdn_off", REG_W'(t3), 24'h0000C8);
    dev(1'b0, PDN_START_ADDR, 24'h000003, q);
    pdn_time(t3);
    dev(1'b0, PDN_START_ADDR, 24'h000006, q);
    pdn_time(t6);
    chk("pdn_delta", REG_W'(t6 - t3), 24'h00000C);
    dev(1'b0, PDN_START_ADDR, 24'h00FFFF, q);
    dev(1'b1, PDN_START_ADDR, 24'h000000, q);
    chk("pdn_start", q, 24'h00FFFF);
    finish_test();
  end
endmodule

// *** verilog/frontend_host.sv ***
`timescale 1ns/1ps
module frontend_host
  import frontend_regs_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Command port.
  input wire logic [2:0] addr,
  input wire logic [REG_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [REG_W-1:0] rdata,
  // Serial link to the device.
  serial_link_if.host link
);
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso_s1;
    logic miso_s2;
    logic [2:0] ph;
    logic [5:0] bit_cnt;
    logic [FRAME_BITS-1:0] sh;
    logic [REG_W-1:0] rx;
    logic busy;
    logic [7:0] cmd;
    logic [REG_W-1:0] data;
    logic [REG_W-1:0] rdata;
  } host_state_t;

  host_state_t st;
  host_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.miso_s1 = link.miso_line;
    next_st.miso_s2 = st.miso_s1;
    next_st.rdata = '0;
    if (rd) begin
      case (addr)
        HOST_ADDR_REG: next_st.rdata[7:0] = st.cmd;
        HOST_DATA_REG: next_st.rdata = st.data;
        HOST_STATUS_REG: next_st.rdata[0] = st.busy;
        HOST_RX_REG: next_st.rdata = st.rx;
        default: next_st.rdata = '0;
      endcase
    end
    if (wr && !st.busy) begin
      case (addr)
        HOST_ADDR_REG: next_st.cmd = wdata[7:0];
        HOST_DATA_REG: next_st.data = wdata;
        HOST_GO_REG: begin
          next_st.busy = 1'b1;
          next_st.cs_n = 1'b0;
          next_st.sh = {st.cmd, st.data};
          next_st.mosi = st.cmd[READ_FLAG_BIT];
          next_st.ph = 3'h0;
          next_st.bit_cnt = 6'h00;
        end
        default: next_st.busy = st.busy;
      endcase
    end
    if (st.busy) begin
      next_st.ph = st.ph + 3'h1;
      if (st.ph == SCLK_HALF - 3'h1) begin
        next_st.ph = 3'h0;
        if (st.cs_n) begin
          next_st.busy = 1'b0;
        end else if (!st.sclk) begin
          next_st.sclk = 1'b1;
        end else begin
          next_st.sclk = 1'b0;
          next_st.rx = {st.rx[REG_W-2:0], st.miso_s2};
          next_st.bit_cnt = st.bit_cnt + 6'h01;
          next_st.sh = {st.sh[FRAME_BITS-2:0], 1'b0};
          next_st.mosi = st.sh[FRAME_BITS-2];
          if (st.bit_cnt == LAST_BIT) begin
            next_st.cs_n = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.cs_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign link.sclk = st.sclk;
  assign link.cs_n = st.cs_n;
  assign link.mosi = st.mosi;
endmodule

// *** verilog/frontend_regs.sv ***
// Functional notes
// - Fault register read-only, bits 23:13 zero.
// - Flags captured when diagnostics done rises.
// - Flag reads 0 no fault, 1 fault.
// - Bit 12 photodiode alarm, bit 11 emitter.
// - Bits 10/9 second/first emitter open.
// - Bit 8 emitter short.
// - Bits 7/6 neg/pos drive to ground.
// - Bit 5 photodiode open, bit 4 short.
// - Bits 3/2 neg/pos input to ground.
// - Bits 1/0 neg/pos input to emitter.
// - Control resets zero; reserved bits written zero.
// - Bit 15 moves positive drive to third.
// - Host limits third emitter current setting.
// - Bit 4 tri-states serial data output.
// - Host tri-states output when bus shared.
// - Bit 3 tri-states divided clock output.
// - Bits 2:0 select divider, two codes illegal.
// - Host matches divider code to clock.
// - Start count 16 bits, resets zero.
// - Start count places power-down pulse start.
// - Zero start count leaves feature off.
`timescale 1ns/1ps
module frontend_regs
  import frontend_regs_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic resetn,
  // Serial link to the host.
  serial_link_if.device link,
  // Diagnostics sequencer.
  input wire logic diagnostics_done_pin,
  input wire logic [FLAG_W-1:0] diagnostic_fault_flags_flags_in,
  // Timing engine.
  input wire logic pos_bridge_ctrl,
  input wire logic neg_bridge_ctrl,
  input wire logic prp_start,
  // Emitter drive, clock and power-down outputs.
  output logic pos_bridge_output,
  output logic neg_bridge_output,
  output logic third_emitter_output,
  output logic divided_clock_output,
  output logic divided_clock_oe,
  output logic dynamic_power_down_start,
  output logic third_emitter_select
);
  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_s3;
    logic cs_s1;
    logic cs_s2;
    logic mosi_s1;
    logic mosi_s2;
    logic [5:0] bit_cnt;
    logic [FRAME_BITS-1:0] in_sh;
    logic [REG_W-1:0] out_sh;
    logic miso;
    logic miso_oe;
    logic done_q;
    logic [FLAG_W-1:0] flags;
    logic [REG_W-1:0] ctrl;
    logic [PDN_W-1:0] pdn_start;
    logic [2:0] div_cnt;
    logic clk_out;
    logic clk_oe;
    logic [PDN_W-1:0] pd_cnt;
    logic pd_pulse;
    logic pos_out;
    logic neg_out;
    logic tx3_out;
  } dev_state_t;

  dev_state_t st;
  dev_state_t next_st;
  logic rise;
  logic fall;
  logic [FRAME_BITS-1:0] word;
  logic [REG_W-1:0] rd_val;
  logic [2:0] half;

  always_comb begin
    next_st = st;
    // The link arrives from another chip, so every line passes two flops first.
    // The third sclk flop only feeds the edge detector and is never a sync stage.
    next_st.sclk_s1 = link.sclk;
    next_st.sclk_s2 = st.sclk_s1;
    next_st.sclk_s3 = st.sclk_s2;
    next_st.cs_s1 = link.cs_n;
    next_st.cs_s2 = st.cs_s1;
    next_st.mosi_s1 = link.mosi;
    next_st.mosi_s2 = st.mosi_s1;
    rise = st.sclk_s2 & ~st.sclk_s3;
    fall = ~st.sclk_s2 & st.sclk_s3;
    word = {st.in_sh[FRAME_BITS-2:0], st.mosi_s2};

    // Read-only flags
    // Upper bits read as zero and writes never reach this register.
    // The value is chosen on the eighth rise, once the address is complete.
    // Unmapped offsets read zero so a wrong address is easy to spot.
    rd_val = REG_RESET;
    case (word[ADDR_W-1:0])
      DIAGNOSTIC_FAULT_FLAGS_FLAGS_ADDR: rd_val[FLAG_W-1:0] = st.flags;
      CTRL_ADDR: rd_val = st.ctrl;
      PDN_START_ADDR: rd_val[PDN_W-1:0] = st.pdn_start;
      default: rd_val = REG_RESET;
    endcase

    if (st.cs_s2) begin
      next_st.bit_cnt = 6'h00;
    end else if (rise) begin
      next_st.in_sh = word;
      next_st.bit_cnt = st.bit_cnt + 6'h01;
      // Loading on the eighth rise leaves half a clock before the first data fall.
      if (st.bit_cnt == ADDR_BITS - 6'h01 && word[READ_FLAG_BIT]) begin
        next_st.out_sh = rd_val;
      end
      if (st.bit_cnt == LAST_BIT && !word[FRAME_BITS-1]) begin
        case (word[REG_W+ADDR_W-1:REG_W])
          // Control write path
          // Reserved control bits are kept as written; the host writes zero.
          CTRL_ADDR: next_st.ctrl = word[REG_W-1:0];
          PDN_START_ADDR: next_st.pdn_start = word[PDN_W-1:0];
          default: next_st.ctrl = st.ctrl;
        endcase
      end
    end else if (fall && st.bit_cnt >= ADDR_BITS) begin
      next_st.miso = st.out_sh[REG_W-1];
      next_st.out_sh = {st.out_sh[REG_W-2:0], 1'b0};
    end
    // Serial output tri-state
    // Also released while deselected so a shared line stays free.
    next_st.miso_oe = ~st.cs_s2 & ~st.ctrl[SERIAL_TRI_BIT];

    next_st.done_q = diagnostics_done_pin;
    if (diagnostics_done_pin && !st.done_q) begin
      next_st.flags = diagnostic_fault_flags_flags_in;
    end

    // Clock divider
    // Divide-by-1 cannot come from a register; it toggles every cycle.
    // A new code applies to the running count at once, so one odd period may follow a write.
    half = div_half(st.ctrl[DIV_LSB+DIV_W-1:DIV_LSB]);
    next_st.div_cnt = st.div_cnt + 3'h1;
    if (st.div_cnt + 3'h1 >= half) begin
      next_st.div_cnt = 3'h0;
      next_st.clk_out = ~st.clk_out;
    end
    next_st.clk_oe = ~st.ctrl[DIVIDED_CLOCK_OUT_TRISTATE_BIT];

    // Zero count disables
    // The count restarts at every period start, so a late write only shifts one period.
    // A start value beyond the period length simply never fires.
    next_st.pd_pulse = 1'b0;
    if (prp_start) begin
      next_st.pd_cnt = '0;
    end else if (next_st.clk_out && !st.clk_out) begin
      next_st.pd_cnt = st.pd_cnt + 16'h0001;
      next_st.pd_pulse = (st.pdn_start != '0) && (st.pd_cnt + 16'h0001 == st.pdn_start);
    end

    // Third emitter routing
    // The idle output is held low so both emitters are never lit at once.
    if (st.ctrl[THIRD_EMITTER_BIT]) begin
      next_st.pos_out = 1'b0;
      next_st.tx3_out = pos_bridge_ctrl;
    end else begin
      next_st.pos_out = pos_bridge_ctrl;
      next_st.tx3_out = 1'b0;
    end
    next_st.neg_out = neg_bridge_ctrl;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      // Select lines reset to their idle level so no false frame start follows reset.
      st <= '0;
      st.sclk_s1 <= 1'b0;
      st.cs_s1 <= 1'b1;
      st.cs_s2 <= 1'b1;
      st.clk_oe <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign link.serial_data_out_pin = st.miso;
  assign link.serial_data_out_oe = st.miso_oe;
  assign pos_bridge_output = st.pos_out;
  assign neg_bridge_output = st.neg_out;
  assign third_emitter_output = st.tx3_out;
  assign divided_clock_output = st.clk_out;
  assign divided_clock_oe = st.clk_oe;
  assign dynamic_power_down_start = st.pd_pulse;
  assign third_emitter_select = st.ctrl[THIRD_EMITTER_BIT];
endmodule

// *** verilog/frontend_regs_pkg.sv ***
package frontend_regs_pkg;
  localparam int REG_W = 24;
  localparam int ADDR_W = 7;
  localparam int FRAME_BITS = 32;
  localparam logic [5:0] ADDR_BITS = 6'h08;
  localparam logic [5:0] LAST_BIT = 6'h1F;
  localparam int FLAG_W = 13;

  // Device register offsets.
  localparam logic [ADDR_W-1:0] DIAGNOSTIC_FAULT_FLAGS_FLAGS_ADDR = 7'h30;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 7'h31;
  localparam logic [ADDR_W-1:0] PDN_START_ADDR = 7'h32;
  localparam logic [REG_W-1:0] REG_RESET = 24'h000000;

  // Control register fields.
  localparam int THIRD_EMITTER_BIT = 15;
  localparam int SERIAL_TRI_BIT = 4;
  localparam int DIVIDED_CLOCK_OUT_TRISTATE_BIT = 3;
  localparam int DIV_LSB = 0;
  localparam int DIV_W = 3;
  localparam int PDN_W = 16;

  // Diagnostic flag positions.
  localparam int PD_ALARM_BIT = 12;
  localparam int EMITTER_ALARM_BIT = 11;
  localparam int EMITTER2_OPEN_BIT = 10;
  localparam int EMITTER1_OPEN_BIT = 9;
  localparam int EMITTER_SHORT_BIT = 8;
  localparam int NEG_DRV_GND_BIT = 7;
  localparam int POS_DRV_GND_BIT = 6;
  localparam int PD_OPEN_BIT = 5;
  localparam int PD_SHORT_BIT = 4;
  localparam int NEG_IN_GND_BIT = 3;
  localparam int POS_IN_GND_BIT = 2;
  localparam int NEG_IN_EMIT_BIT = 1;
  localparam int POS_IN_EMIT_BIT = 0;

  // Divider codes.
  localparam logic [DIV_W-1:0] DIV_BY_2 = 3'h0;
  localparam logic [DIV_W-1:0] DIV_BY_4 = 3'h2;
  localparam logic [DIV_W-1:0] DIV_BY_6 = 3'h3;
  localparam logic [DIV_W-1:0] DIV_BY_8 = 3'h4;
  localparam logic [DIV_W-1:0] DIV_BY_12 = 3'h5;
  localparam logic [DIV_W-1:0] DIV_BY_1 = 3'h7;

  // Host command port offsets and fields.
  localparam logic [2:0] HOST_ADDR_REG = 3'h0;
  localparam logic [2:0] HOST_DATA_REG = 3'h1;
  localparam logic [2:0] HOST_GO_REG = 3'h2;
  localparam logic [2:0] HOST_STATUS_REG = 3'h3;
  localparam logic [2:0] HOST_RX_REG = 3'h4;
  localparam int READ_FLAG_BIT = 7;

  // Serial clock half period in system clock cycles.
  localparam logic [2:0] SCLK_HALF = 3'h4;

  // Half period of the divided clock, in system clock cycles.
  function automatic logic [2:0] div_half(input logic [DIV_W-1:0] code);
    case (code)
      DIV_BY_4: div_half = 3'h2;
      DIV_BY_6: div_half = 3'h3;
      DIV_BY_8: div_half = 3'h4;
      DIV_BY_12: div_half = 3'h6;
      default: div_half = 3'h1;
    endcase
  endfunction
endpackage

// *** verilog/serial_link_if.sv ***
`timescale 1ns/1ps
interface serial_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic serial_data_out_pin;
  logic serial_data_out_oe;
  logic miso_line;

  // Undriven line is read as low.
  assign miso_line = serial_data_out_oe & serial_data_out_pin;

  modport device (
    input sclk,
    input cs_n,
    input mosi,
    output serial_data_out_pin,
    output serial_data_out_oe
  );
  modport host (
    output sclk,
    output cs_n,
    output mosi,
    input miso_line
  );
endinterface
